// ===== logic/coinc_ctrl_regs.vh
// Constants for the coincidence and auxiliary I/O control block.
`ifndef COINC_CTRL_REGS_VH
`define COINC_CTRL_REGS_VH
`define CLK_FREQ_HZ        10000000
`define DEAD_STORE_MS      1
`define DEAD_STORE_CYC     ((`CLK_FREQ_HZ / 1000) * `DEAD_STORE_MS)
`define NUM_GROUPS         4
`define MODE_INACTIVE      2'h0
`define MODE_SINGLE        2'h1
`define MODE_COINC         2'h2
`define SEL_COINC_START    4'h0
`define SEL_COINC_RUN      4'h1
`define SEL_COINC_ACTIVE   4'h2
`define SEL_DEAD_STORE     4'h3
`define SEL_ENABLE_ALL     4'h4
`define SEL_ONE            4'h5
`define SEL_ZERO           4'h6
`define SEL_RUNNING        4'h7
`define SEL_PRESET_REACHED 4'h8
`define SEL_TIMER_LOAD     4'h9
`define DIG_STATUS_BIT     0
`define DIG_TRIGGER_BIT    6
`endif

// ===== logic/coinc_ctrl.v
// Coincidence resolving, auxiliary connector and digital port control.
`timescale 1ns/10ps
`default_nettype none
`include "coinc_ctrl_regs.vh"
module coinc_ctrl #(
    parameter NUM_ADC   = 4,
    parameter WIN_CYC   = 40,
    parameter PROC_CYC  = 20,
    parameter MS_CYC    = `DEAD_STORE_CYC
) (
    input  wire                   mclk,
    input  wire                   sys_rst,
    input  wire [2*NUM_ADC-1:0]   adc_mode,
    input  wire [NUM_ADC-1:0]     adc_start_en,
    input  wire [4*NUM_ADC-1:0]   group_mask,
    input  wire [NUM_ADC-1:0]     adc_data,
    input  wire                   enable_all,
    input  wire                   running,
    input  wire                   rtc_fitted,
    input  wire                   preset_reached,
    input  wire                   halt_on_preset,
    input  wire                   timer_load,
    input  wire [1:0]             aux_coinc_en,
    input  wire [1:0]             aux_start_en,
    input  wire [1:0]             aux_low_active,
    input  wire [1:0]             aux_out_en,
    input  wire [3:0]             auxiliary_connector_one_sel,
    input  wire [3:0]             auxiliary_connector_two_sel,
    input  wire                   auxiliary_connector_one_i,
    input  wire                   auxiliary_connector_two_i,
    input  wire                   event_reject_input,
    input  wire                   rej_coinc_en,
    input  wire                   rej_low_active,
    input  wire                   rej_at_end,
    input  wire [3:0]             rej_group_mask,
    input  wire                   status_en,
    input  wire                   counter_en,
    input  wire [7:0]             counter_load,
    input  wire                   counter_load_stb,
    input  wire                   trig_en,
    input  wire                   trig_invert,
    input  wire                   trig_clear_en,
    input  wire                   start_cmd,
    input  wire                   stop_cmd,
    input  wire [7:0]             dig_in,
    output reg                    auxiliary_connector_one_o,
    output reg                    auxiliary_connector_one_oe,
    output reg                    auxiliary_connector_two_o,
    output reg                    auxiliary_connector_two_oe,
    output reg  [7:0]             dig_out,
    output reg                    acq_on,
    output reg                    clear_data,
    output reg                    event_accept,
    output reg                    event_drop,
    output reg  [NUM_ADC-1:0]     single_accept
);

    localparam ST_IDLE = 2'h0;
    localparam ST_WIN  = 2'h1;
    localparam ST_PROC = 2'h2;

    // Polarity-corrected auxiliary and reject levels.
    wire auxiliary_connector_one_act = auxiliary_connector_one_i ^ aux_low_active[0];
    wire auxiliary_connector_two_act = auxiliary_connector_two_i ^ aux_low_active[1];
    wire rej_act  = event_reject_input ^ rej_low_active;
    // An auxiliary connector driving out never feeds coincidence.
    wire auxiliary_connector_one_in  = auxiliary_connector_one_act & aux_coinc_en[0] & ~aux_out_en[0];
    wire auxiliary_connector_two_in  = auxiliary_connector_two_act & aux_coinc_en[1] & ~aux_out_en[1];
    wire aux_or   = auxiliary_connector_one_in | auxiliary_connector_two_in;
    wire aux_start = (auxiliary_connector_one_in & aux_start_en[0]) | (auxiliary_connector_two_in & aux_start_en[1]);

    // Per-converter decode of mode and window-start ability.
    wire [NUM_ADC-1:0] is_coinc;
    wire [NUM_ADC-1:0] is_single;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_ADC; gi = gi + 1) begin : g_adc
            assign is_coinc[gi]  = adc_mode[2*gi +: 2] == `MODE_COINC;
            assign is_single[gi] = adc_mode[2*gi +: 2] == `MODE_SINGLE;
        end
    endgenerate
    wire adc_start = |(adc_data & is_coinc & adc_start_en);
    wire open_req  = enable_all & (adc_start | aux_start);

    reg [1:0]           state_q;
    reg [15:0]          tmr_q;
    reg [NUM_ADC-1:0]   seen_q;
    reg [3:0]           drop_grp_q;
    reg                 win_pulse_q;

    // Group check: each group needs every coincidence-mode member present in the window.
    wire [NUM_ADC-1:0] seen_now = seen_q | (adc_data & is_coinc);
    wire [3:0] grp_miss;
    wire [3:0] grp_hit;
    generate
        for (gi = 0; gi < `NUM_GROUPS; gi = gi + 1) begin : g_grp
            assign grp_miss[gi] = |(group_mask[NUM_ADC*gi +: NUM_ADC] & is_coinc & ~seen_now);
            assign grp_hit[gi]  = |(group_mask[NUM_ADC*gi +: NUM_ADC] & seen_now);
        end
    endgenerate
    // Groups hit by a reject; a reject with no group mask hits the whole event.
    wire [3:0] rej_grp = (rej_group_mask == 4'h0) ? 4'hf : rej_group_mask;
    wire rej_now = rej_act & rej_coinc_en;
    // A reject only discards an event that reaches one of its groups; all groups means any event.
    wire rej_hit_now = rej_now & ((rej_grp == 4'hf) | (|(rej_grp & grp_hit)));
    wire rej_hit_end = (drop_grp_q == 4'hf) | (|(drop_grp_q & grp_hit));

    // Window state machine: idle, window open, processing.
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q      <= ST_IDLE;
            tmr_q        <= 16'h0000;
            seen_q       <= {NUM_ADC{1'b0}};
            drop_grp_q   <= 4'h0;
            win_pulse_q  <= 1'b0;
            event_accept <= 1'b0;
            event_drop   <= 1'b0;
        end else begin
            win_pulse_q  <= 1'b0;
            event_accept <= 1'b0;
            event_drop   <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (open_req) begin
                        state_q     <= ST_WIN;
                        win_pulse_q <= 1'b1;
                        tmr_q       <= WIN_CYC[15:0];
                        seen_q      <= adc_data & is_coinc;
                        drop_grp_q  <= 4'h0;
                    end
                end
                ST_WIN: begin
                    seen_q <= seen_now;
                    if (rej_now)
                        drop_grp_q <= drop_grp_q | rej_grp;
                    if (rej_hit_now && !rej_at_end) begin
                        // Instant reject ends the event at once.
                        event_drop <= 1'b1;
                        state_q    <= ST_PROC;
                        tmr_q      <= PROC_CYC[15:0];
                    end else if (tmr_q <= 16'h0001) begin
                        // An auxiliary input level joined to coincidence at close counts as present data.
                        if ((|grp_miss) || rej_hit_end || rej_hit_now || (~|seen_now && !aux_or))
                            event_drop <= 1'b1;
                        else
                            event_accept <= 1'b1;
                        state_q <= ST_PROC;
                        tmr_q   <= PROC_CYC[15:0];
                    end else begin
                        tmr_q <= tmr_q - 16'h0001;
                    end
                end
                ST_PROC: begin
                    if (tmr_q <= 16'h0001)
                        state_q <= ST_IDLE;
                    else
                        tmr_q <= tmr_q - 16'h0001;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Singles are accepted regardless of any window.
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            single_accept <= {NUM_ADC{1'b0}};
        else
            single_accept <= adc_data & is_single & {NUM_ADC{enable_all}};
    end

    // Millisecond divider for the dead-time sample request.
    reg [23:0] ms_q;
    reg        dead_q;
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ms_q   <= 24'h000000;
            dead_q <= 1'b0;
        end else if (!enable_all) begin
            ms_q   <= 24'h000000;
            dead_q <= 1'b0;
        end else if (ms_q >= MS_CYC - 1) begin
            ms_q   <= 24'h000000;
            dead_q <= 1'b1;
        end else begin
            ms_q   <= ms_q + 24'h000001;
            dead_q <= 1'b0;
        end
    end

    // Output selector; the running copy is open drain so only low is driven.
    function [1:0] sel_fn;
        input [3:0] sel;
        input       second;
        begin
            case (sel)
                `SEL_COINC_START:    sel_fn = {win_pulse_q, 1'b1};
                `SEL_COINC_RUN:      sel_fn = {state_q == ST_WIN, 1'b1};
                `SEL_COINC_ACTIVE:   sel_fn = {state_q != ST_IDLE, 1'b1};
                `SEL_DEAD_STORE:     sel_fn = {dead_q, 1'b1};
                `SEL_ENABLE_ALL:     sel_fn = {enable_all, 1'b1};
                `SEL_ONE:            sel_fn = 2'h3;
                `SEL_ZERO:           sel_fn = 2'h1;
                `SEL_RUNNING:        sel_fn = {1'b0, ~running};
                `SEL_PRESET_REACHED: sel_fn = {second & rtc_fitted & halt_on_preset & preset_reached, 1'b1};
                `SEL_TIMER_LOAD:     sel_fn = {second & rtc_fitted & timer_load, 1'b1};
                default:             sel_fn = 2'h1;
            endcase
        end
    endfunction

    wire [1:0] auxiliary_connector_one_drv = sel_fn(auxiliary_connector_one_sel, 1'b0);
    wire [1:0] auxiliary_connector_two_drv = sel_fn(auxiliary_connector_two_sel, 1'b1);

    // Connector drive registers.
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            auxiliary_connector_one_o  <= 1'b0;
            auxiliary_connector_one_oe <= 1'b0;
            auxiliary_connector_two_o  <= 1'b0;
            auxiliary_connector_two_oe <= 1'b0;
        end else begin
            auxiliary_connector_one_o  <= auxiliary_connector_one_drv[1];
            auxiliary_connector_one_oe <= aux_out_en[0] & auxiliary_connector_one_drv[0];
            auxiliary_connector_two_o  <= auxiliary_connector_two_drv[1];
            auxiliary_connector_two_oe <= aux_out_en[1] & auxiliary_connector_two_drv[0];
        end
    end

    // Acquisition control with external trigger on digital input six.
    reg       armed_q;
    reg       trig_prev_q;
    reg [7:0] cnt_q;
    wire trig_act  = dig_in[`DIG_TRIGGER_BIT] ^ trig_invert;
    wire trig_go   = trig_prev_q & ~trig_act;
    wire trig_halt = ~trig_prev_q & trig_act;
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            acq_on      <= 1'b0;
            armed_q     <= 1'b0;
            trig_prev_q <= 1'b1;
            clear_data  <= 1'b0;
            cnt_q       <= 8'h00;
        end else begin
            trig_prev_q <= trig_act;
            clear_data  <= 1'b0;
            if (counter_load_stb)
                cnt_q <= counter_load;
            if (stop_cmd) begin
                armed_q <= 1'b0;
                acq_on  <= 1'b0;
            end else if (start_cmd) begin
                if (trig_en) begin
                    armed_q    <= 1'b1;
                    clear_data <= trig_clear_en;
                end else begin
                    acq_on <= 1'b1;
                end
            end else if (armed_q && trig_go && !acq_on) begin
                acq_on     <= 1'b1;
                clear_data <= trig_clear_en;
            end else if (armed_q && trig_halt) begin
                acq_on <= 1'b0;
            end
            // A run stop bumps the port value.
            if (acq_on && (stop_cmd || (armed_q && trig_halt)) && !counter_load_stb)
                cnt_q <= cnt_q + 8'h01;
        end
    end

    // Digital port drive.
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            dig_out <= 8'h00;
        else if (counter_en)
            dig_out <= cnt_q;
        else if (status_en)
            dig_out <= {7'h00, acq_on};
        else
            dig_out <= 8'h00;
    end

endmodule
`default_nettype wire

// ===== sim/coinc_ctrl_asserts.sv
// Concurrent checks on the ports of the coincidence control block.
`timescale 1ns/10ps
`default_nettype none
`include "coinc_ctrl_regs.vh"
module coinc_ctrl_chk #(
    parameter NUM_ADC = 4
) (
    input wire logic                 mclk,
    input wire logic                 sys_rst,
    input wire logic [2*NUM_ADC-1:0] adc_mode,
    input wire logic [NUM_ADC-1:0]   adc_data,
    input wire logic                 enable_all,
    input wire logic                 running,
    input wire logic                 status_en,
    input wire logic                 counter_en,
    input wire logic [1:0]           aux_out_en,
    input wire logic [3:0]           auxiliary_connector_one_sel,
    input wire logic                 auxiliary_connector_one_o,
    input wire logic                 auxiliary_connector_one_oe,
    input wire logic [7:0]           dig_out,
    input wire logic                 acq_on,
    input wire logic                 event_accept,
    input wire logic                 event_drop,
    input wire logic [NUM_ADC-1:0]   single_accept
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Outputs are registered, so a selection is held two cycles (three for the dead-time request and the status bit) before its effect is judged.
    a_start_pulse: assert property (
        $rose(auxiliary_connector_one_o) && aux_out_en[0] && auxiliary_connector_one_sel == `SEL_COINC_START
        |=> !auxiliary_connector_one_o) else $error("window start pulse too long");
    a_sel_one: assert property (
        (aux_out_en[0] && auxiliary_connector_one_sel == `SEL_ONE) [*2] |-> auxiliary_connector_one_o && auxiliary_connector_one_oe)
        else $error("constant high not driven");
    a_sel_zero: assert property (
        (aux_out_en[0] && auxiliary_connector_one_sel == `SEL_ZERO) [*2] |-> !auxiliary_connector_one_o && auxiliary_connector_one_oe)
        else $error("constant low not driven");
    a_oe_off: assert property (
        (!aux_out_en[0]) [*2] |-> !auxiliary_connector_one_oe) else $error("connector driven while an input");
    a_drain_release: assert property (
        (aux_out_en[0] && auxiliary_connector_one_sel == `SEL_RUNNING && running) [*2] |-> !auxiliary_connector_one_oe)
        else $error("open drain output driving high");
    a_enable_copy: assert property (
        (aux_out_en[0] && auxiliary_connector_one_sel == `SEL_ENABLE_ALL && enable_all) [*2] |-> auxiliary_connector_one_o)
        else $error("enable copy missing");
    a_dead_quiet: assert property (
        (auxiliary_connector_one_sel == `SEL_DEAD_STORE && !enable_all) [*3] |-> !auxiliary_connector_one_o)
        else $error("sample request while disabled");
    a_status_bit: assert property (
        (status_en && !counter_en && acq_on) [*3] |-> dig_out[0]) else $error("status bit clear while on");
    a_verdict_excl: assert property (
        !(event_accept && event_drop)) else $error("accept and drop together");
    a_single_pass: assert property (
        adc_mode[1:0] == `MODE_SINGLE && adc_data[0] && enable_all && running |-> ##[1:2] single_accept[0])
        else $error("single not accepted");
endmodule
bind coinc_ctrl coinc_ctrl_chk #(.NUM_ADC(NUM_ADC)) i_coinc_ctrl_chk (.mclk, .sys_rst, .adc_mode, .adc_data,
    .enable_all, .running, .status_en, .counter_en, .aux_out_en, .auxiliary_connector_one_sel, .auxiliary_connector_one_o,
    .auxiliary_connector_one_oe, .dig_out, .acq_on, .event_accept, .event_drop, .single_accept);
`default_nettype wire

// ===== sim/front_stub.sv
// Stand-in for the converters and the TTL sources facing the control block.
`timescale 1ns/10ps
`default_nettype none
module front_stub (
    input  wire logic       mclk,
    input  wire logic [3:0] fire,
    input  wire logic [1:0] ttl_req,
    output var  logic [3:0] adc_data = 4'h0,
    output var  logic [1:0] ttl_pin = 2'h0
);
    // Sources always drive a level, as a TTL output does; data lasts as long as it is asked for.
    always @(posedge mclk) begin
        adc_data <= #1 fire;
        ttl_pin <= #1 ttl_req;
    end
endmodule
`default_nettype wire

// ===== sim/tb_coinc_ctrl.sv
// Self-checking bench for the coincidence and auxiliary connector control block.
`timescale 1ns/10ps
`default_nettype none
`include "coinc_ctrl_regs.vh"
module tb_coinc_ctrl;
    localparam int WIN = 8;
    logic        mclk = 1'h0, sys_rst = 1'h1, enable_all = 1'h0, running = 1'h0, rtc_fitted = 1'h0;
    logic        preset_reached = 1'h0, halt_on_preset = 1'h0, timer_load = 1'h0, rej = 1'h1, rej_coinc_en = 1'h0;
    logic        rej_low_active = 1'h1, rej_at_end = 1'h0, status_en = 1'h0, counter_en = 1'h0, trig_en = 1'h0;
    logic        counter_load_stb = 1'h0, trig_invert = 1'h0, trig_clear_en = 1'h0, start_cmd = 1'h0, stop_cmd = 1'h0;
    logic        pin_one, pin_two, one_o, one_oe, two_o, two_oe, acq_on, clear_data, event_accept, event_drop;
    logic [1:0]  aux_coinc_en = 2'h0, aux_start_en = 2'h0, aux_low_active = 2'h0, aux_out_en = 2'h0, ttl_req = 2'h0, ttl_pin;
    logic [3:0]  adc_start_en = 4'h0, auxiliary_connector_one_sel = 4'h0, auxiliary_connector_two_sel = 4'h0, rej_group_mask = 4'h0, fire = 4'h0;
    logic [3:0]  adc_data, single_accept;
    logic [7:0]  adc_mode = 8'h0, counter_load = 8'h0, dig_in = 8'hff, dig_out;
    logic [15:0] group_mask = 16'h0;
    int          n_fail = 0, checked = 0, hits, waited;
    // A pin set as output shows the block's own level; otherwise the source drives it.
    assign pin_one = one_oe ? one_o : ttl_pin[0];
    assign pin_two = two_oe ? two_o : ttl_pin[1];
    initial begin
        forever #50 mclk = ~mclk;
    end
    front_stub i_front_stub (.mclk, .fire, .ttl_req, .adc_data, .ttl_pin);
    coinc_ctrl #(.WIN_CYC(WIN), .PROC_CYC(4), .MS_CYC(20)) i_coinc_ctrl (.mclk, .sys_rst, .adc_mode, .adc_start_en,
        .group_mask, .adc_data, .enable_all, .running, .rtc_fitted, .preset_reached, .halt_on_preset, .timer_load,
        .aux_coinc_en, .aux_start_en, .aux_low_active, .aux_out_en, .auxiliary_connector_one_sel, .auxiliary_connector_two_sel,
        .auxiliary_connector_one_i(pin_one), .auxiliary_connector_two_i(pin_two), .event_reject_input(rej),
        .rej_coinc_en, .rej_low_active, .rej_at_end, .rej_group_mask, .status_en, .counter_en, .counter_load,
        .counter_load_stb, .trig_en, .trig_invert, .trig_clear_en, .start_cmd, .stop_cmd, .dig_in,
        .auxiliary_connector_one_o(one_o), .auxiliary_connector_one_oe(one_oe), .auxiliary_connector_two_o(two_o),
        .auxiliary_connector_two_oe(two_oe), .dig_out, .acq_on, .clear_data, .event_accept, .event_drop,
        .single_accept);
    // Inputs move one nanosecond after the edge so no race with the design's sampling.
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        step(1);
        s = 1'h0;
        step(3);
    endtask
    // Fires converters, then waits for a verdict; hits counts cycles the first connector is high.
    task automatic shot(input logic [3:0] f, input int lim);
        fire = f;
        step(1);
        fire = 4'h0;
        hits = 0;
        waited = 0;
        while (event_accept !== 1'h1 && event_drop !== 1'h1 && waited < lim) begin
            step(1);
            waited++;
            hits += one_o;
        end
    endtask
    task automatic tally;
        hits = 0;
        repeat (60) begin
            step(1);
            hits += one_o;
        end
    endtask
    // Opens a window with converters 0 and 1, then holds the reject active until a verdict.
    task automatic rej_shot;
        step(20);
        fire = 4'h3;
        step(3);
        fire = 4'h0;
        rej = 1'h0;
        shot(4'h0, 30);
        rej = 1'h1;
    endtask
    task automatic t_coinc;
        enable_all = 1'h1;
        running = 1'h1;
        adc_mode = 8'h01;
        shot(4'h1, 1);
        chk(single_accept, 8'h1);
        adc_mode = 8'haa;
        adc_start_en = 4'hf;
        group_mask = 16'h0013;
        aux_out_en = 2'h1;
        shot(4'h3, 30);
        chk(event_accept, 8'h1);
        chk(hits, 8'h1);
        step(20);
        shot(4'h1, 30);
        chk(event_drop, 8'h1);
        rej_coinc_en = 1'h1;
        rej_shot;
        chk(event_drop, 8'h1);
        chk(waited < WIN, 8'h1);
        // A reject held to window end drops the event only when the window closes.
        rej_at_end = 1'h1;
        rej_shot;
        chk(event_drop, 8'h1);
        chk(waited, 8'(WIN - 2));
        // A reject aimed at an empty group leaves the event alone.
        rej_group_mask = 4'h4;
        rej_shot;
        chk(event_accept, 8'h1);
        {rej_coinc_en, rej_at_end, rej_group_mask} = 6'h00;
        step(20);
        adc_start_en = 4'h0;
        shot(4'h3, 30);
        chk(waited, 8'h1e);
    endtask
    // Auxiliary input opens a window only when it joins coincidence and may start one.
    task automatic t_aux;
        aux_out_en = 2'h0;
        aux_start_en = 2'h1;
        ttl_req = 2'h1;
        shot(4'h0, 30);
        chk(waited, 8'h1e);
        aux_coinc_en = 2'h1;
        shot(4'h0, 30);
        ttl_req = 2'h0;
        chk(waited < 30, 8'h1);
        step(20);
        // A low level on connector two counts as active once its polarity is inverted.
        {aux_coinc_en, aux_start_en, aux_low_active} = 6'h2a;
        shot(4'h0, 30);
        aux_low_active = 2'h0;
        chk(waited < 30, 8'h1);
        step(20);
    endtask
    task automatic t_sel;
        aux_out_en = 2'h3;
        for (int i = 4; i < 7; i++) begin
            auxiliary_connector_one_sel = 4'(i);
            step(2);
            chk(one_o, i != 6);
        end
        auxiliary_connector_one_sel = `SEL_RUNNING;
        running = 1'h0;
        step(2);
        chk({one_oe, one_o}, 8'h2);
        running = 1'h1;
        step(2);
        chk(one_oe, 8'h0);
        {rtc_fitted, halt_on_preset, preset_reached} = 3'h7;
        auxiliary_connector_two_sel = `SEL_PRESET_REACHED;
        step(2);
        chk(two_o, 8'h1);
        halt_on_preset = 1'h0;
        step(2);
        chk(two_o, 8'h0);
        auxiliary_connector_two_sel = `SEL_TIMER_LOAD;
        timer_load = 1'h1;
        step(2);
        chk({two_oe, two_o}, 8'h3);
        timer_load = 1'h0;
        auxiliary_connector_one_sel = `SEL_DEAD_STORE;
        tally;
        chk(hits, 8'h3);
        enable_all = 1'h0;
        // A request launched just before the enable fell may still be on the pin for one cycle.
        step(1);
        tally;
        chk(hits, 8'h0);
        enable_all = 1'h1;
    endtask
    // Counter wraps from the top value on a stop; trigger edges then run the acquisition.
    task automatic t_port;
        counter_en = 1'h1;
        counter_load = 8'hff;
        pulse(counter_load_stb);
        chk(dig_out, 8'hff);
        pulse(start_cmd);
        pulse(stop_cmd);
        chk(dig_out, 8'h00);
        counter_en = 1'h0;
        status_en = 1'h1;
        trig_en = 1'h1;
        trig_clear_en = 1'h1;
        pulse(start_cmd);
        chk(acq_on, 8'h0);
        dig_in[6] = 1'h0;
        step(1);
        chk(clear_data, 8'h1);
        step(2);
        chk({acq_on, dig_out[0]}, 8'h3);
        dig_in[6] = 1'h1;
        step(3);
        chk(acq_on, 8'h0);
        dig_in[6] = 1'h0;
        step(3);
        chk(acq_on, 8'h1);
        pulse(stop_cmd);
        dig_in[6] = 1'h1;
        step(3);
        dig_in[6] = 1'h0;
        step(3);
        chk(acq_on, 8'h0);
        trig_invert = 1'h1;
        pulse(start_cmd);
        dig_in[6] = 1'h1;
        step(3);
        chk(acq_on, 8'h1);
        pulse(stop_cmd);
    endtask
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #(5000 * 100);
        n_fail++;
        summarize;
    end
    initial begin
        step(8);
        sys_rst = 1'h0;
        step(2);
        t_coinc;
        t_aux;
        t_sel;
        t_port;
        summarize;
    end
endmodule
`default_nettype wire
